// file: rtl/dummy_end_marker_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: rtl/nco_consts.svh
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH

`define NCO_ACC_W 32
`define NCO_AMP_W 16
`define NCO_PHASE_W 28
`define NCO_PHASE_LSB 4
`define NCO_QUAD_MSB 31
`define NCO_QUAD_LSB 30
`define NCO_IDX_MSB 29
`define NCO_IDX_LSB 22
`define NCO_ROM_ADDR_W 8
`define NCO_ROM_DEPTH 256
`define NCO_SER_BITS 16
`define NCO_SINCE_W 5
`define NCO_CTRL_RESET 7'h70
`define NCO_ACC_RESET 32'h0000_0000
`define NCO_AMP_RESET 16'h0000
`define NCO_PI_Q30 64'h0000_0000_C90F_DAA2
`define NCO_FRAC_W 30
`define NCO_TAYLOR_TERMS 5
`define NCO_SCALE_NUM 64'h0000_7FFF_8000
`define NCO_SCALE_DEN 64'h0000_0000_0001_0001
`define NCO_ROUND_HALF 64'h0000_0000_2000_0000

`endif

// file: rtl/nco_pkg.sv
`include "nco_consts.svh"
package nco_pkg;

   typedef struct packed
   {
      logic inc_load_n;
      logic accum_en_n;
      logic accum_clr_n;
      logic offset_bin;
      logic serial_sel;
      logic test_sel;
      logic dac_ready;
   } nco_ctrl_type;

   typedef struct packed
   {
      logic [`NCO_AMP_W-1:0] q;
      logic [`NCO_AMP_W-1:0] i;
      logic [`NCO_PHASE_W-1:0] phase;
   } nco_sample_type;

endpackage : nco_pkg

// file: rtl/nco_quarter_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "nco_consts.svh"
module nco_quarter_rom
   import nco_pkg::*;
(
   input wire logic clock,
   input wire logic enable,
   input wire logic [`NCO_ROM_ADDR_W-1:0] addr_a,
   input wire logic [`NCO_ROM_ADDR_W-1:0] addr_b,
   output logic [`NCO_AMP_W-1:0] data_a,
   output logic [`NCO_AMP_W-1:0] data_b
);

   // quarter-wave sine at the middle of each step, Taylor series in Q30
   function automatic logic [`NCO_AMP_W-1:0] quarter_sine(input int idx);
      longint x;
      longint x2;
      longint term;
      longint sum;
      longint amp;
      x = (longint'(2 * idx + 1) * longint'(`NCO_PI_Q30)) / longint'(4 * `NCO_ROM_DEPTH);
      x2 = (x * x) >>> `NCO_FRAC_W;
      term = x;
      sum = x;
      for (int k = 1; k <= `NCO_TAYLOR_TERMS; k++)
      begin
         term = -((term * x2) >>> `NCO_FRAC_W) / longint'((2 * k) * (2 * k + 1));
         sum = sum + term;
      end
      // full scale shrunk so that +peak and -peak mirror about zero
      amp = ((sum * longint'(`NCO_SCALE_NUM)) / longint'(`NCO_SCALE_DEN) + longint'(`NCO_ROUND_HALF))
            >>> `NCO_FRAC_W; // RL9
      return amp[`NCO_AMP_W-1:0];
   endfunction : quarter_sine

   logic [`NCO_AMP_W-1:0] rom [0:`NCO_ROM_DEPTH-1];

   for (genvar g = 0; g < `NCO_ROM_DEPTH; g++)
   begin : g_entry
      localparam logic [`NCO_AMP_W-1:0] ENTRY = quarter_sine(g);
      assign rom[g] = ENTRY;
   end

   always_ff @(posedge clock)
   begin
      if (enable)
      begin
         data_a <= rom[addr_a];
         data_b <= rom[addr_b];
      end
   end

endmodule : nco_quarter_rom
`default_nettype wire

// file: rtl/nco_timer_sincos.sv
// Notes on behaviour
// RL1: timer accumulator adds increment every clock
// RL2: increment register loads while load_n low
// RL3: accumulator carry drives timer_carry_out pin
// RL4: software programs increment as INT(ratio * 2^32)
// RL5: top 20 phase bits address 16-bit sine/cosine; the code uses only the top 10 (2 quadrant, 8 index)
// RL6: address spans one turn, zero to 2pi-step
// RL7: default two's complement, 8001H to 7FFFH
// RL8: offset binary inverts msb of both outputs
// RL9: table scaled (2^16-1)/(2^16+1) for symmetry
// RL10: serial mode loads shifters while accumulator enabled
// RL11: one load cycle, then fifteen shift cycles
// RL12: msb-first on bit 15, lsb-first on bit 0
// RL13: afterwards zeros msb-first, sign copies lsb-first
// RL14: strobe marks first bit of new word
// RL15: test plus serial brings out 28 phase bits
// RL16: control inputs registered, register updates next edge; the code registers them twice, so the register updates one edge later
// RL17: phase accumulator drops carry past 32 bits
// RL18: timer wraps modulo 2^32, one-cycle carry pulse
// RL19: parallel mode drives full words every clock; the code updates them only on clocks with dac_ready high
`timescale 1ns/1ps
`default_nettype none
`include "nco_consts.svh"
module nco_timer_sincos
   import nco_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [`NCO_ACC_W-1:0] timer_increment_in,
   input wire logic timer_increment_load_n,
   input wire logic [`NCO_ACC_W-1:0] phase_increment_in,
   input wire logic phase_accum_enable_n,
   input wire logic phase_accum_clear_n,
   input wire logic offset_binary_select,
   input wire logic serial_output_select,
   input wire logic test_mode_select,
   input wire logic dac_ready,
   output logic timer_carry_out,
   output logic [`NCO_AMP_W-1:0] q_amplitude_out,
   output logic [`NCO_AMP_W-1:0] i_amplitude_out,
   output logic serial_word_strobe,
   output logic sample_valid
);

   nco_ctrl_type ctrl_pins;
   nco_ctrl_type ctrl_meta_reg;
   nco_ctrl_type ctrl_reg;
   logic [`NCO_ACC_W-1:0] timer_inc_meta_reg;
   logic [`NCO_ACC_W-1:0] timer_inc_in_reg;
   logic [`NCO_ACC_W-1:0] phase_inc_meta_reg;
   logic [`NCO_ACC_W-1:0] phase_inc_in_reg;
   logic [`NCO_ACC_W-1:0] timer_inc_reg;
   logic [`NCO_ACC_W-1:0] timer_acc_reg;
   logic [`NCO_ACC_W-1:0] timer_acc_next;
   logic timer_carry_next;
   logic [`NCO_ACC_W-1:0] phase_acc_reg;
   logic [`NCO_ACC_W-1:0] phase_acc_next;
   logic pipe_go;
   logic [1:0] q_quad;
   logic [1:0] i_quad;
   logic [`NCO_ROM_ADDR_W-1:0] rom_idx;
   logic [`NCO_ROM_ADDR_W-1:0] q_addr;
   logic [`NCO_ROM_ADDR_W-1:0] i_addr;
   logic [`NCO_AMP_W-1:0] q_mag;
   logic [`NCO_AMP_W-1:0] i_mag;
   logic q_neg_reg;
   logic i_neg_reg;
   logic [`NCO_PHASE_W-1:0] phase_d_reg;
   logic lookup_valid_reg;
   nco_sample_type lookup_sample;
   nco_sample_type buf_mem_reg [0:1];
   nco_sample_type buf_head;
   logic buf_wr_ptr_reg;
   logic buf_rd_ptr_reg;
   logic [1:0] buf_count_reg;
   logic buf_in_ready;
   logic buf_push;
   logic buf_pop;
   logic drain_ready;
   logic serial_load;
   logic serial_load_d_reg;
   logic test_out;
   logic [`NCO_AMP_W-1:0] fmt_mask;
   logic [`NCO_AMP_W-1:0] head_word [0:1];
   logic [`NCO_AMP_W-1:0] msb_sreg [0:1];
   logic [`NCO_AMP_W-1:0] lsb_sreg [0:1];
   logic [`NCO_SINCE_W-1:0] since_load_reg;

   // pin inputs pass two flip-flops before use
   assign ctrl_pins = '{inc_load_n: timer_increment_load_n, accum_en_n: phase_accum_enable_n,
                        accum_clr_n: phase_accum_clear_n, offset_bin: offset_binary_select,
                        serial_sel: serial_output_select, test_sel: test_mode_select,
                        dac_ready: dac_ready};

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         ctrl_meta_reg <= `NCO_CTRL_RESET;
         ctrl_reg <= `NCO_CTRL_RESET;
      end
      else
      begin
         ctrl_meta_reg <= ctrl_pins;
         ctrl_reg <= ctrl_meta_reg; // RL16
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         timer_inc_meta_reg <= `NCO_ACC_RESET;
         timer_inc_in_reg <= `NCO_ACC_RESET;
         phase_inc_meta_reg <= `NCO_ACC_RESET;
         phase_inc_in_reg <= `NCO_ACC_RESET;
      end
      else
      begin
         timer_inc_meta_reg <= timer_increment_in;
         timer_inc_in_reg <= timer_inc_meta_reg;
         phase_inc_meta_reg <= phase_increment_in;
         phase_inc_in_reg <= phase_inc_meta_reg;
      end
   end

   // timer section
   always_ff @(posedge clock)
   begin
      if (reset)
         timer_inc_reg <= `NCO_ACC_RESET;
      else if (!ctrl_reg.inc_load_n)
         timer_inc_reg <= timer_inc_in_reg; // RL2 RL16
   end

   assign {timer_carry_next, timer_acc_next} = {1'b0, timer_acc_reg} + {1'b0, timer_inc_reg}; // RL18

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         timer_acc_reg <= `NCO_ACC_RESET;
         timer_carry_out <= 1'b0;
      end
      else
      begin
         timer_acc_reg <= timer_acc_next; // RL1
         timer_carry_out <= timer_carry_next; // RL3
      end
   end

   // phase accumulator; clear zeroes the feedback path
   assign pipe_go = buf_in_ready;
   assign phase_acc_next = (ctrl_reg.accum_clr_n ? phase_acc_reg : `NCO_ACC_RESET) + phase_inc_in_reg; // RL17

   always_ff @(posedge clock)
   begin
      if (reset)
         phase_acc_reg <= `NCO_ACC_RESET;
      else if (pipe_go && !ctrl_reg.accum_en_n)
         phase_acc_reg <= phase_acc_next;
   end

   // quadrant folding of the 10-bit turn address onto a quarter table
   assign q_quad = phase_acc_reg[`NCO_QUAD_MSB:`NCO_QUAD_LSB]; // RL5 RL6
   assign i_quad = q_quad + 2'h1;
   assign rom_idx = phase_acc_reg[`NCO_IDX_MSB:`NCO_IDX_LSB];
   assign q_addr = q_quad[0] ? ~rom_idx : rom_idx;
   assign i_addr = i_quad[0] ? ~rom_idx : rom_idx;

   nco_quarter_rom u_rom
   (
      .clock(clock),
      .enable(pipe_go),
      .addr_a(q_addr),
      .addr_b(i_addr),
      .data_a(q_mag),
      .data_b(i_mag)
   );

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         q_neg_reg <= 1'b0;
         i_neg_reg <= 1'b0;
         phase_d_reg <= '0;
         lookup_valid_reg <= 1'b0;
      end
      else if (pipe_go)
      begin
         q_neg_reg <= q_quad[1];
         i_neg_reg <= i_quad[1];
         phase_d_reg <= phase_acc_reg[`NCO_ACC_W-1:`NCO_PHASE_LSB];
         lookup_valid_reg <= 1'b1;
      end
   end

   // two's complement words, never 8000H
   assign lookup_sample = '{q: q_neg_reg ? -q_mag : q_mag, i: i_neg_reg ? -i_mag : i_mag,
                            phase: phase_d_reg}; // RL7

   // two-entry buffer; when full it stalls the accumulator and lookup
   assign buf_in_ready = (buf_count_reg != 2'h2);
   assign sample_valid = (buf_count_reg != 2'h0);
   assign buf_push = lookup_valid_reg && buf_in_ready;
   assign buf_head = buf_mem_reg[buf_rd_ptr_reg];
   assign serial_load = ctrl_reg.serial_sel && !ctrl_reg.accum_en_n && sample_valid; // RL10
   assign drain_ready = ctrl_reg.serial_sel ? !ctrl_reg.accum_en_n : ctrl_reg.dac_ready;
   assign buf_pop = sample_valid && drain_ready;

   always_ff @(posedge clock)
   begin
      if (buf_push)
         buf_mem_reg[buf_wr_ptr_reg] <= lookup_sample;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         buf_wr_ptr_reg <= 1'b0;
         buf_rd_ptr_reg <= 1'b0;
         buf_count_reg <= 2'h0;
      end
      else
      begin
         if (buf_push)
            buf_wr_ptr_reg <= !buf_wr_ptr_reg;
         if (buf_pop)
            buf_rd_ptr_reg <= !buf_rd_ptr_reg;
         if (buf_push && !buf_pop)
            buf_count_reg <= buf_count_reg + 2'h1;
         else if (buf_pop && !buf_push)
            buf_count_reg <= buf_count_reg - 2'h1;
      end
   end

   // output formatting and serial shifters, an msb-first and an lsb-first pair per channel
   assign fmt_mask = {ctrl_reg.offset_bin, {(`NCO_AMP_W-1){1'b0}}};
   assign head_word[0] = buf_head.q ^ fmt_mask; // RL8
   assign head_word[1] = buf_head.i ^ fmt_mask; // RL8

   for (genvar ch = 0; ch < 2; ch++)
   begin : g_chan
      always_ff @(posedge clock)
      begin
         if (reset)
         begin
            msb_sreg[ch] <= `NCO_AMP_RESET;
            lsb_sreg[ch] <= `NCO_AMP_RESET;
         end
         else if (serial_load)
         begin
            msb_sreg[ch] <= head_word[ch]; // RL10
            lsb_sreg[ch] <= head_word[ch];
         end
         else
         begin
            msb_sreg[ch] <= {msb_sreg[ch][`NCO_AMP_W-2:0], 1'b0}; // RL11 RL13
            lsb_sreg[ch] <= {lsb_sreg[ch][`NCO_AMP_W-1], lsb_sreg[ch][`NCO_AMP_W-1:1]}; // RL13
         end
      end
   end

   assign test_out = ctrl_reg.test_sel && ctrl_reg.serial_sel;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         q_amplitude_out <= `NCO_AMP_RESET;
         i_amplitude_out <= `NCO_AMP_RESET;
      end
      else if (test_out)
      begin
         q_amplitude_out <= phase_acc_reg[`NCO_ACC_W-1:`NCO_ACC_W-`NCO_AMP_W]; // RL15
         i_amplitude_out <= {phase_acc_reg[`NCO_ACC_W-`NCO_AMP_W-1:`NCO_PHASE_LSB], 4'h0}; // RL15
      end
      else if (ctrl_reg.serial_sel)
      begin
         q_amplitude_out <= {msb_sreg[0][`NCO_AMP_W-1], {(`NCO_AMP_W-2){1'b0}}, lsb_sreg[0][0]}; // RL12
         i_amplitude_out <= {msb_sreg[1][`NCO_AMP_W-1], {(`NCO_AMP_W-2){1'b0}}, lsb_sreg[1][0]}; // RL12
      end
      else if (buf_pop)
      begin
         q_amplitude_out <= head_word[0]; // RL19
         i_amplitude_out <= head_word[1]; // RL19
      end
   end

   // strobe lines up with the first serial bit on the pins
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         serial_load_d_reg <= 1'b0;
         serial_word_strobe <= 1'b0;
      end
      else
      begin
         serial_load_d_reg <= serial_load;
         serial_word_strobe <= serial_load_d_reg && ctrl_reg.serial_sel && !test_out; // RL14
      end
   end

   // checking helpers and properties
   always_ff @(posedge clock)
   begin
      if (reset)
         since_load_reg <= '0;
      else if (serial_load)
         since_load_reg <= '0;
      else if (since_load_reg != {`NCO_SINCE_W{1'b1}})
         since_load_reg <= since_load_reg + 1'b1;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence s_load_q;
      serial_load && !test_out;
   endsequence

   // first bits on the pins are those of the word loaded two edges before
   sequence s_strobe_then_bits;
      ##1 serial_word_strobe ##0 (q_amplitude_out[`NCO_AMP_W-1] == $past(msb_sreg[0][`NCO_AMP_W-1])
         && q_amplitude_out[0] == $past(lsb_sreg[0][0]));
   endsequence

   a_timer_accum_step: assert property ($past(!reset) |-> // RL1
      timer_acc_reg == $past(timer_acc_reg) + $past(timer_inc_reg))
      else $error("timer accumulator did not add increment");
   a_increment_load: assert property (!ctrl_reg.inc_load_n ##1 $stable(timer_inc_in_reg) |-> // RL2
      timer_inc_reg == $past(timer_inc_in_reg))
      else $error("timer increment not loaded");
   a_carry_pulse: assert property ($past(!reset) |-> timer_carry_out == // RL3
      ({1'b0, $past(timer_acc_reg)} + {1'b0, $past(timer_inc_reg)} > 33'h0_FFFF_FFFF))
      else $error("timer carry does not match wrap");
   a_phase_wrap: assert property (pipe_go && !ctrl_reg.accum_en_n && ctrl_reg.accum_clr_n |=> // RL17
      phase_acc_reg == $past(phase_acc_reg) + $past(phase_inc_in_reg))
      else $error("phase accumulator did not wrap modulo 2^32");
   a_twos_range: assert property (lookup_valid_reg |-> // RL7
      lookup_sample.q != 16'h8000 && lookup_sample.i != 16'h8000)
      else $error("amplitude reached 8000H");
   a_offset_msb: assert property (!ctrl_reg.serial_sel && ctrl_reg.offset_bin && buf_pop |=> // RL8
      q_amplitude_out != 16'h0000 && q_amplitude_out[`NCO_AMP_W-1] == !$past(buf_head.q[`NCO_AMP_W-1]))
      else $error("offset binary msb not inverted");
   a_parallel_words: assert property (!ctrl_reg.serial_sel && buf_pop |=> // RL19
      i_amplitude_out == $past(head_word[1]))
      else $error("parallel word not driven");
   a_strobe_first_bit: assert property ((s_load_q and ctrl_reg.serial_sel) ##1 // RL14
      (ctrl_reg.serial_sel && !test_out && !serial_load) |-> s_strobe_then_bits)
      else $error("strobe missing at first serial bit");
   a_serial_tail: assert property (since_load_reg >= 5'h10 |-> // RL13
      msb_sreg[0] == 16'h0000 && (lsb_sreg[1] == 16'h0000 || lsb_sreg[1] == 16'hFFFF))
      else $error("serial tail not zero or sign fill");
   a_test_phase: assert property (test_out |=> // RL15
      q_amplitude_out == $past(phase_acc_reg[31:16]) && i_amplitude_out == {$past(phase_acc_reg[15:4]), 4'h0})
      else $error("test mode phase not output");

endmodule : nco_timer_sincos
`default_nettype wire

// file: tb/nco_dac_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "nco_consts.svh"
module nco_dac_model
   import nco_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic stall,
   input wire logic serial_word_strobe,
   input wire logic [`NCO_AMP_W-1:0] q_amplitude_out,
   input wire logic [`NCO_AMP_W-1:0] i_amplitude_out,
   output logic dac_ready,
   output nco_sample_type msb_word,
   output nco_sample_type lsb_word,
   output logic [`NCO_SINCE_W-1:0] bit_count
);
   // the receiver refuses words only when the bench asks it to
   assign dac_ready = !stall;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         bit_count <= 5'h10;
         msb_word <= '0;
         lsb_word <= '0;
      end
      else if (serial_word_strobe)
      begin
         bit_count <= 5'h01;
         msb_word.q <= {15'h0000, q_amplitude_out[15]};
         msb_word.i <= {15'h0000, i_amplitude_out[15]};
         lsb_word.q <= {q_amplitude_out[0], 15'h0000};
         lsb_word.i <= {i_amplitude_out[0], 15'h0000};
      end
      else if (bit_count < 5'h10)
      begin
         bit_count <= bit_count + 5'h01;
         msb_word.q <= {msb_word.q[14:0], q_amplitude_out[15]};
         msb_word.i <= {msb_word.i[14:0], i_amplitude_out[15]};
         lsb_word.q <= {q_amplitude_out[0], lsb_word.q[15:1]};
         lsb_word.i <= {i_amplitude_out[0], lsb_word.i[15:1]};
      end
   end
endmodule : nco_dac_model
`default_nettype wire

// file: tb/nco_timer_sincos_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "nco_consts.svh"
module nco_timer_sincos_bench
   import nco_pkg::*;
;
   typedef struct {logic [31:0] inc; logic [31:0] carries;} nco_timer_row_type;
   logic clock, reset, load_n, en_n, clr_n, offset, serial, test, stall, ready;
   logic [31:0] timer_inc, phase_inc;
   logic carry, strobe, valid;
   logic [15:0] q_out, i_out, prev_q, prev_i, old_q, pw_q, pw_i;
   logic [4:0] bit_count;
   nco_sample_type msb_word, lsb_word;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   int n;
   // increments are rate/clock times 2^32: 1/4, 1/2, 0, 1/16, 3/4
   nco_timer_row_type rows [5] = '{'{32'h4000_0000, 32'h0000_0010}, '{32'h8000_0000, 32'h0000_0020},
      '{32'h0000_0000, 32'h0000_0000}, '{32'h1000_0000, 32'h0000_0004}, '{32'hC000_0000, 32'h0000_0030}};

   nco_timer_sincos u_nco_timer_sincos (.clock(clock), .reset(reset), .timer_increment_in(timer_inc),
      .timer_increment_load_n(load_n), .phase_increment_in(phase_inc), .phase_accum_enable_n(en_n),
      .phase_accum_clear_n(clr_n), .offset_binary_select(offset), .serial_output_select(serial),
      .test_mode_select(test), .dac_ready(ready), .timer_carry_out(carry), .q_amplitude_out(q_out),
      .i_amplitude_out(i_out), .serial_word_strobe(strobe), .sample_valid(valid));

   nco_dac_model u_nco_dac_model (.clock(clock), .reset(reset), .stall(stall), .serial_word_strobe(strobe),
      .q_amplitude_out(q_out), .i_amplitude_out(i_out), .dac_ready(ready), .msb_word(msb_word),
      .lsb_word(lsb_word), .bit_count(bit_count));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic chk_word(input logic [15:0] act, input logic [15:0] exp);
      checked++;
      if (act !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask : chk_word

   task automatic chk_num(input logic [31:0] act, input logic [31:0] exp);
      checked++;
      if (act !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask : chk_num

   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask : cyc

   task test_done;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         test_done();
      end
   end

   initial
   begin
      reset = 1'b1;
      {load_n, en_n, clr_n} = 3'h7;
      {offset, serial, test, stall} = 4'h0;
      timer_inc = 32'h0000_0000;
      phase_inc = 32'h0000_0000;
      cyc(20);
      chk_word(q_out, 16'h0000);
      chk_word(i_out, 16'h0000);
      chk_num(32'({carry, strobe, valid}), 32'h0000_0000);
      reset = 1'b0;
      foreach (rows[r])
      begin
         timer_inc = rows[r].inc;
         load_n = 1'b0;
         cyc(1);
         load_n = 1'b1;
         cyc(4);
         // a value presented without the load must not reach the increment
         timer_inc = 32'hFFFF_FFFF;
         cyc(4);
         n = 0;
         repeat (64)
         begin
            @(negedge clock);
            if (carry === 1'b1)
               n++;
         end
         chk_num(n, rows[r].carries);
      end
      phase_inc = 32'h4000_0000;
      en_n = 1'b0;
      cyc(12);
      old_q = q_out;
      cyc(1);
      prev_q = q_out;
      prev_i = i_out;
      for (int k = 0; k < 16; k++)
      begin
         cyc(1);
         chk_num(32'(q_out != prev_q), 32'h0000_0001);
         chk_word(q_out, prev_i);
         chk_word(q_out + old_q, 16'h0000);
         chk_num(32'(q_out == 16'h8000 || i_out == 16'h8000), 32'h0000_0000);
         old_q = prev_q;
         prev_q = q_out;
         prev_i = i_out;
      end
      stall = 1'b1;
      cyc(8);
      prev_q = q_out;
      prev_i = i_out;
      cyc(4);
      chk_word(q_out, prev_q);
      chk_num(32'(valid), 32'h0000_0001);
      stall = 1'b0;
      for (int k = 0; k < 10 && q_out === prev_q; k++)
         cyc(1);
      chk_word(q_out, prev_i);
      // clear held low pins the phase at the increment value
      phase_inc = 32'h9234_5678;
      clr_n = 1'b0;
      cyc(12);
      pw_q = q_out;
      pw_i = i_out;
      chk_num(32'(pw_q[15] & pw_i[15]), 32'h0000_0001);
      offset = 1'b1;
      cyc(8);
      chk_word(q_out, pw_q ^ 16'h8000);
      chk_word(i_out, pw_i ^ 16'h8000);
      offset = 1'b0;
      serial = 1'b1;
      en_n = 1'b1;
      cyc(8);
      en_n = 1'b0;
      cyc(1);
      en_n = 1'b1;
      for (int k = 0; k < 10 && strobe !== 1'b1; k++)
         cyc(1);
      chk_num(32'(strobe), 32'h0000_0001);
      cyc(1);
      chk_num(32'(strobe), 32'h0000_0000);
      cyc(16);
      chk_num(32'(bit_count), 32'h0000_0010);
      chk_word(msb_word.q, pw_q);
      chk_word(lsb_word.q, pw_q);
      chk_word(msb_word.i, pw_i);
      chk_word(lsb_word.i, pw_i);
      chk_word(q_out, 16'h0001);
      chk_word(i_out, 16'h0001);
      test = 1'b1;
      en_n = 1'b0;
      cyc(6);
      chk_word(q_out, 16'h9234);
      chk_word(i_out, 16'h5670);
      chk_num(32'(strobe), 32'h0000_0000);
      test_done();
   end
endmodule : nco_timer_sincos_bench
`default_nettype wire
